// >>> hdl/frame_counter_mapping_regs.vh
`ifndef FRAME_COUNTER_MAPPING_REGS_VH
`define FRAME_COUNTER_MAPPING_REGS_VH

// Counter widths and wrap points
`define FRAME_WIDTH 12
`define FRAME_MAX 12'hfff
`define CONN_WIDTH 8
`define CONN_MAX 8'hff
`define FRAME_ZERO 12'h000
`define CONN_ZERO 8'h00

// Variant selector
`define VARIANT_FDD 1'b0
`define VARIANT_TDD 1'b1

// Offset report cases
`define CASE_SINGLE 2'h0
`define CASE_MULTI 2'h1
`define CASE_ADD 2'h2

// Neighbour offset table depth
`define NB_ADDR_WIDTH 5

`endif

// >>> hdl/neighbour_offset_mem.v
`timescale 1ns/10ps
`include "frame_counter_mapping_regs.vh"

// Small table of neighbour cell frame number low bytes, registered read data
module neighbour_offset_mem (
    input wire sys_clk,
    input wire clk_en,
    input wire wr_en,
    input wire [`NB_ADDR_WIDTH-1:0] wr_addr,
    input wire [`CONN_WIDTH-1:0] wr_data,
    input wire [`NB_ADDR_WIDTH-1:0] rd_addr,
    output reg [`CONN_WIDTH-1:0] rd_data
);

reg [`CONN_WIDTH-1:0] mem [0:(1<<`NB_ADDR_WIDTH)-1];

always @(posedge sys_clk) begin
    if (clk_en) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
end

endmodule // neighbour_offset_mem

// >>> hdl/frame_counter_mapping.v
`timescale 1ns/10ps
`include "frame_counter_mapping_regs.vh"

// How it works
// RULE1 - Base station counter counts 0..4095, wraps
// RULE2 - Controller counter counts 0..4095, wraps
// RULE3 - Cell counter 0..4095, broadcast as timebase
// RULE4 - FDD: cell counter equals base plus adjustment
// RULE5 - TDD sync port: cell low byte follows base
// RULE6 - Connection counter 0..255, paging 0..4095
// RULE7 - Each block set carries connection frame number
// RULE8 - Downlink: cell low byte = conn plus offset
// RULE9 - Uplink: conn = cell minus offset, mod 256
// RULE10 - One-frame steps, 8-bit offsets, low bits
// RULE11 - Connection wrap exceeds MAC-to-L1 delay
// RULE12 - Controller supplies per-link frame offset
// RULE13 - Report offset only when network requests
// RULE14 - Network flags known or measured neighbours
// RULE15 - Reported offset is 0..255 frames
// RULE16 - Single link entry reports zero offset
// RULE17 - FDD multi link: offset minus first cell
// RULE18 - Link add: connection minus target cell frame
// RULE19 - All counters step on frame strobe, reset zero
module frame_counter_mapping (
    input wire sys_clk,
    input wire nrst,
    input wire clk_en,
    input wire frame_strobe,
    input wire variant_tdd,
    input wire sync_port_used,
    input wire [`FRAME_WIDTH-1:0] cell_adjust,
    input wire paging_channel,
    input wire [`CONN_WIDTH-1:0] link_frame_offset,
    input wire link_offset_load,
    input wire dl_block_valid,
    input wire [`CONN_WIDTH-1:0] dl_conn_frame,
    input wire ul_block_valid,
    input wire [`FRAME_WIDTH-1:0] ul_cell_frame,
    input wire nb_known_wr,
    input wire [`NB_ADDR_WIDTH-1:0] nb_addr,
    input wire [`CONN_WIDTH-1:0] nb_frame_low,
    input wire nb_known,
    input wire report_req,
    input wire [1:0] report_case,
    input wire [`NB_ADDR_WIDTH-1:0] report_addr,
    input wire report_is_first,
    output reg [`FRAME_WIDTH-1:0] base_station_frame_counter,
    output reg [`FRAME_WIDTH-1:0] controller_frame_counter,
    output reg [`FRAME_WIDTH-1:0] cell_system_frame_counter,
    output reg [`FRAME_WIDTH-1:0] connection_frame_counter,
    output reg dl_valid,
    output reg [`CONN_WIDTH-1:0] dl_cell_frame_low,
    output reg [`CONN_WIDTH-1:0] dl_tag_conn_frame,
    output reg ul_valid,
    output reg [`CONN_WIDTH-1:0] ul_conn_frame,
    output reg report_valid,
    output reg report_skipped,
    output reg [`CONN_WIDTH-1:0] report_offset
);

////////////////////////////////////////////////////////////////////////////////
// Reset release

reg rst_meta;
reg rst_sync;

always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        rst_meta <= 1'b0;
        rst_sync <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_sync <= rst_meta;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Modulo-256 and modulo-4096 arithmetic

function [`CONN_WIDTH-1:0] add256;
    input [`CONN_WIDTH-1:0] a;
    input [`CONN_WIDTH-1:0] b;
    reg [`CONN_WIDTH:0] s;
    begin
        s = {1'b0, a} + {1'b0, b};
        add256 = s[`CONN_WIDTH-1:0];
    end
endfunction

function [`CONN_WIDTH-1:0] sub256;
    input [`CONN_WIDTH-1:0] a;
    input [`CONN_WIDTH-1:0] b;
    reg [`CONN_WIDTH:0] s;
    begin
        s = {1'b0, a} - {1'b0, b};
        sub256 = s[`CONN_WIDTH-1:0];
    end
endfunction

function [`FRAME_WIDTH-1:0] inc4096;
    input [`FRAME_WIDTH-1:0] a;
    begin
        // An explicit compare with FRAME_MAX gives the wrap at 4095
        if (a == `FRAME_MAX) begin
            inc4096 = `FRAME_ZERO;
        end else begin
            inc4096 = a + 12'h001;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Frame counters

reg [`CONN_WIDTH-1:0] link_offset;
reg [`FRAME_WIDTH-1:0] next_base;
reg [`FRAME_WIDTH-1:0] next_cell;
reg [`FRAME_WIDTH-1:0] next_conn;
reg [`FRAME_WIDTH:0] cell_sum;
reg [`FRAME_WIDTH-1:0] cell_inc;

always @* begin
    next_base = inc4096(base_station_frame_counter); // see RULE1
    cell_inc = inc4096(cell_system_frame_counter);
    cell_sum = {1'b0, next_base} + {1'b0, cell_adjust};
    if (variant_tdd == `VARIANT_FDD) begin
        next_cell = cell_sum[`FRAME_WIDTH-1:0]; // see RULE4
    end else if (sync_port_used) begin
        // Upper bits keep counting freely, low byte locked
        next_cell = {cell_inc[`FRAME_WIDTH-1:`CONN_WIDTH],
                     next_base[`CONN_WIDTH-1:0]}; // see RULE5
    end else begin
        next_cell = cell_inc; // see RULE3
    end
    if (paging_channel) begin
        next_conn = inc4096(connection_frame_counter); // see RULE6
    end else begin
        next_conn = {4'h0, add256(connection_frame_counter[`CONN_WIDTH-1:0], 8'h01)}; // see RULE6
    end
end

always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
        base_station_frame_counter <= `FRAME_ZERO; // see RULE19
        controller_frame_counter <= `FRAME_ZERO;
        cell_system_frame_counter <= `FRAME_ZERO;
        connection_frame_counter <= `FRAME_ZERO;
        link_offset <= `CONN_ZERO;
    end else if (clk_en) begin
        if (link_offset_load) begin
            link_offset <= link_frame_offset; // see RULE12
        end
        if (frame_strobe) begin
            base_station_frame_counter <= next_base; // see RULE19
            controller_frame_counter <= inc4096(controller_frame_counter); // see RULE2
            cell_system_frame_counter <= next_cell; // see RULE3
            connection_frame_counter <= next_conn; // see RULE11
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Layer 1 / layer 2 frame mapping

always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
        dl_valid <= 1'b0;
        dl_cell_frame_low <= `CONN_ZERO;
        dl_tag_conn_frame <= `CONN_ZERO;
        ul_valid <= 1'b0;
        ul_conn_frame <= `CONN_ZERO;
    end else if (clk_en) begin
        dl_valid <= dl_block_valid;
        ul_valid <= ul_block_valid;
        if (dl_block_valid) begin
            dl_tag_conn_frame <= dl_conn_frame; // see RULE7
            dl_cell_frame_low <= add256(dl_conn_frame, link_offset); // see RULE8
        end
        if (ul_block_valid) begin
            // Only the low byte of the cell frame is meaningful here
            ul_conn_frame <= sub256(ul_cell_frame[`CONN_WIDTH-1:0], link_offset); // see RULE9 see RULE10
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Neighbour offset report

wire [`CONN_WIDTH-1:0] nb_rd_data;
reg first_cell_known;
reg [`CONN_WIDTH-1:0] first_cell_frame;
reg [`NB_ADDR_WIDTH-1:0] nb_known_flags_addr;
reg [(1<<`NB_ADDR_WIDTH)-1:0] nb_known_flags;
reg pend;
reg [1:0] pend_case;
reg pend_first;
reg [`NB_ADDR_WIDTH-1:0] pend_addr;

neighbour_offset_mem u_mem (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .wr_en(nb_known_wr),
    .wr_addr(nb_addr),
    .wr_data(nb_frame_low),
    .rd_addr(report_addr),
    .rd_data(nb_rd_data)
);

always @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
        nb_known_flags <= {(1<<`NB_ADDR_WIDTH){1'b0}};
        nb_known_flags_addr <= {`NB_ADDR_WIDTH{1'b0}};
        first_cell_known <= 1'b0;
        first_cell_frame <= `CONN_ZERO;
        pend <= 1'b0;
        pend_case <= `CASE_SINGLE;
        pend_first <= 1'b0;
        pend_addr <= {`NB_ADDR_WIDTH{1'b0}};
        report_valid <= 1'b0;
        report_skipped <= 1'b0;
        report_offset <= `CONN_ZERO;
    end else if (clk_en) begin
        if (nb_known_wr) begin
            nb_known_flags[nb_addr] <= nb_known; // see RULE14
            nb_known_flags_addr <= nb_addr;
        end
        // Request is taken now, memory data arrive one cycle later
        pend <= report_req; // see RULE13
        pend_case <= report_case;
        pend_first <= report_is_first;
        pend_addr <= report_addr;
        report_valid <= 1'b0;
        report_skipped <= 1'b0;
        if (pend) begin
            if (nb_known_flags[pend_addr]) begin
                report_skipped <= 1'b1; // see RULE14
            end else begin
                report_valid <= 1'b1; // see RULE13
                case (pend_case)
                    `CASE_SINGLE: begin
                        report_offset <= `CONN_ZERO; // see RULE16
                    end
                    `CASE_MULTI: begin
                        if (pend_first || variant_tdd == `VARIANT_TDD) begin
                            report_offset <= `CONN_ZERO; // see RULE17
                            first_cell_frame <= nb_rd_data;
                            first_cell_known <= 1'b1;
                        end else begin
                            report_offset <= sub256(nb_rd_data, first_cell_frame); // see RULE17 see RULE15
                        end
                    end
                    `CASE_ADD: begin
                        report_offset <= sub256(connection_frame_counter[`CONN_WIDTH-1:0],
                                                nb_rd_data); // see RULE18
                    end
                    default: begin
                        report_offset <= `CONN_ZERO;
                    end
                endcase
            end
        end
    end
end

endmodule // frame_counter_mapping

// >>> dv/far_side_model.sv
`timescale 1ns/10ps
module far_side_model (
    input wire sys_clk,
    output reg [7:0] link_frame_offset,
    output reg link_offset_load,
    output reg nb_known_wr,
    output reg [4:0] nb_addr,
    output reg [7:0] nb_frame_low,
    output reg nb_known
);
    initial begin
        {link_frame_offset, link_offset_load, nb_known_wr, nb_addr, nb_frame_low, nb_known} = 0;
    end
    // Per-link offset worked out on this side; offset and frame data lines inverted once idle so stale values never match
    task load(input [7:0] o);
        @(posedge sys_clk);
        link_frame_offset <= o;
        link_offset_load <= 1'b1;
        @(posedge sys_clk);
        link_offset_load <= 1'b0;
        link_frame_offset <= ~o;
    endtask
    task write_nb(input [4:0] a, input [7:0] f, input k);
        @(posedge sys_clk);
        {nb_known_wr, nb_addr, nb_frame_low, nb_known} <= {1'b1, a, f, k};
        @(posedge sys_clk);
        nb_known_wr <= 1'b0;
        nb_frame_low <= ~f;
    endtask
endmodule // far_side_model

// >>> dv/frame_counter_mapping_asserts.sv
`timescale 1ns/10ps
module fcm_chk (
    input wire sys_clk, nrst, clk_en, frame_strobe, variant_tdd, sync_port_used, paging_channel,
    input wire link_offset_load, dl_block_valid, ul_block_valid, report_req,
    input wire [11:0] cell_adjust, ul_cell_frame,
    input wire [7:0] link_frame_offset, dl_conn_frame,
    input wire [1:0] report_case,
    input wire [11:0] base_station_frame_counter, cell_system_frame_counter, connection_frame_counter,
    input wire dl_valid, ul_valid, report_valid, report_skipped,
    input wire [7:0] dl_cell_frame_low, dl_tag_conn_frame, ul_conn_frame, report_offset
);
    reg [7:0] ofs;
    reg rel_meta;
    reg rel_done;
    wire st = clk_en && frame_strobe;
    wire [11:0] b = base_station_frame_counter;
    wire [11:0] s = cell_system_frame_counter;
    wire [11:0] n = connection_frame_counter;
    // Shadow of the loaded offset; a block taken on the load edge still sees the old one
    always @(posedge sys_clk or negedge nrst)
        if (!nrst)
            ofs <= 8'h00;
        else if (clk_en && link_offset_load)
            ofs <= link_frame_offset;
    // The design leaves reset two edges after nrst rises, so checks wait as long
    always @(posedge sys_clk or negedge nrst)
        if (!nrst)
            {rel_meta, rel_done} <= 2'b00;
        else
            {rel_meta, rel_done} <= {1'b1, rel_meta};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rel_done);
    property p_base; st |=> b == 12'($past(b) + 12'h001); endproperty
    a_base: assert property (p_base) else $error("base step");
    property p_hold; clk_en && !frame_strobe |=> $stable(b) && $stable(n); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_fdd; st && !variant_tdd |=> s == 12'(b + $past(cell_adjust)); endproperty
    a_fdd: assert property (p_fdd) else $error("fdd cell");
    property p_tdd; st && variant_tdd && sync_port_used |=> s[7:0] == b[7:0]; endproperty
    a_tdd: assert property (p_tdd) else $error("tdd cell");
    property p_conn; st && !paging_channel |=> n[7:0] == 8'($past(n[7:0]) + 8'h01); endproperty
    a_conn: assert property (p_conn) else $error("conn step");
    property p_dl; clk_en && dl_block_valid |=> dl_valid && dl_tag_conn_frame == $past(dl_conn_frame)
        && dl_cell_frame_low == 8'($past(dl_conn_frame) + $past(ofs)); endproperty
    a_dl: assert property (p_dl) else $error("downlink map");
    property p_ul; clk_en && ul_block_valid |=> ul_valid
        && ul_conn_frame == 8'($past(ul_cell_frame[7:0]) - $past(ofs)); endproperty
    a_ul: assert property (p_ul) else $error("uplink map");
    property p_rep; clk_en && report_req |=> ##1 report_valid != report_skipped; endproperty
    a_rep: assert property (p_rep) else $error("report answer");
    property p_unreq; report_valid |-> $past(report_req, 2); endproperty
    a_unreq: assert property (p_unreq) else $error("unrequested report");
    property p_single; report_req && report_case == 2'h0 |-> ##2 (report_skipped || report_offset == 8'h00);
    endproperty
    a_single: assert property (p_single) else $error("single link");
endmodule // fcm_chk
bind frame_counter_mapping fcm_chk u_chk(.*);

// >>> dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    reg sys_clk, nrst, clk_en, frame_strobe, variant_tdd, sync_port_used, paging_channel;
    reg dl_block_valid, ul_block_valid, report_req, report_is_first;
    reg [11:0] cell_adjust, ul_cell_frame;
    reg [7:0] dl_conn_frame, ofs, r1, r2;
    reg [1:0] report_case;
    reg [4:0] report_addr;
    wire [7:0] link_frame_offset, nb_frame_low, dl_cell_frame_low, dl_tag_conn_frame, ul_conn_frame, report_offset;
    wire link_offset_load, nb_known_wr, nb_known, dl_valid, ul_valid, report_valid, report_skipped;
    wire [4:0] nb_addr;
    wire [11:0] base_station_frame_counter, controller_frame_counter;
    wire [11:0] cell_system_frame_counter, connection_frame_counter;
    integer fail_count, n_tests, seed, cyc, k;
    reg [15:0] qd[$], qu[$], qr[$];
    frame_counter_mapping DUT(.*);
    far_side_model part(.*);
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    task cmp(input [15:0] g, e);
        n_tests = n_tests + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task step(input integer m);
        repeat (m) @(posedge sys_clk) frame_strobe <= 1'b1;
        @(posedge sys_clk) frame_strobe <= 1'b0;
        @(posedge sys_clk) #1;
    endtask
    task rep(input [1:0] c, input [4:0] a, input f, input [9:0] e);
        @(posedge sys_clk) {report_req, report_case, report_addr, report_is_first} <= {1'b1, c, a, f};
        qr.push_back(e);
    endtask
    task drst;
        @(posedge sys_clk) nrst <= 1'b0;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk) #1;
    endtask
    // Results are taken a step after the edge so they have settled
    always @(posedge sys_clk) #1 begin
        if (dl_valid) cmp({dl_cell_frame_low, dl_tag_conn_frame}, qd.pop_front());
        if (ul_valid) cmp(ul_conn_frame, qu.pop_front());
        if (report_valid | report_skipped)
            cmp(report_skipped ? 16'h200 : {8'h01, report_offset}, qr.pop_front());
    end
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            conclude;
        end
    end
    initial begin
        {fail_count, n_tests, cyc, frame_strobe, variant_tdd, sync_port_used, paging_channel} = 0;
        {dl_block_valid, ul_block_valid, report_req, report_is_first, report_case, report_addr} = 0;
        {dl_conn_frame, ul_cell_frame, nrst} = 0;
        {seed, clk_en, cell_adjust} = {32'd41, 1'b1, 12'h005};
        drst;
        cmp(base_station_frame_counter | connection_frame_counter, 16'h0);
        cmp(controller_frame_counter | cell_system_frame_counter, 16'h0);
        step(300);
        cmp(base_station_frame_counter, 16'd300);
        cmp(controller_frame_counter, 16'd300);
        cmp(cell_system_frame_counter, 16'd305);
        cmp(connection_frame_counter, 16'd44);
        step(3796);
        cmp({base_station_frame_counter, connection_frame_counter[3:0]}, 16'h0);
        cmp({controller_frame_counter, cell_system_frame_counter[3:0]}, 16'h5);
        clk_en <= 1'b0;
        step(2);
        clk_en <= 1'b1;
        cmp(base_station_frame_counter, 16'h0);
        $display("counters done");
        ofs = $random(seed);
        part.load(ofs);
        for (k = 0; k < 8; k = k + 1) begin
            @(posedge sys_clk) {dl_block_valid, dl_conn_frame} <= {1'b1, 8'($random(seed))};
            #1 qd.push_back({8'(dl_conn_frame + ofs), dl_conn_frame});
        end
        for (k = 0; k < 8; k = k + 1) begin
            @(posedge sys_clk) {dl_block_valid, ul_block_valid, ul_cell_frame} <= {2'b01, 12'($random(seed))};
            #1 qu.push_back(8'(ul_cell_frame[7:0] - ofs));
        end
        @(posedge sys_clk) ul_block_valid <= 1'b0;
        $display("mapping done");
        {r1, r2} = $random(seed);
        part.write_nb(5'd1, 8'h33, 1'b1);
        part.write_nb(5'd2, r1, 1'b0);
        part.write_nb(5'd3, r2, 1'b0);
        rep(2'h0, 5'd2, 1'b0, 10'h100);
        rep(2'h1, 5'd2, 1'b1, 10'h100);
        rep(2'h1, 5'd3, 1'b0, {2'b01, 8'(r2 - r1)});
        rep(2'h2, 5'd3, 1'b0, {2'b01, 8'(8'h00 - r2)});
        rep(2'h3, 5'd2, 1'b0, 10'h100);
        rep(2'h2, 5'd1, 1'b0, 10'h200);
        @(posedge sys_clk) report_req <= 1'b0;
        {variant_tdd, sync_port_used} <= 2'b11;
        step(5);
        cmp(cell_system_frame_counter[7:0], 16'h05);
        $display("reports done");
        paging_channel <= 1'b1;
        drst;
        step(300);
        cmp(connection_frame_counter, 16'd300);
        repeat (4) @(posedge sys_clk);
        cmp(qd.size() + qu.size() + qr.size(), 16'h0);
        $display("paging done");
        conclude;
    end
endmodule // tb_top
